// ==== logic/ihp_pkg.sv ====
// Constants, types and register map of the indirect register host port.
// Assumes the host strobes and select lines are already synchronous to core_clk.
//
// Contract
// - Select lines are captured at the falling edge of the write strobe.
// - Write byte is latched from the data bus at the write strobe rising edge.
// - Read captures select at strobe fall, drives data until the strobe rises.
// - Select 00 is set, 01 index, 10 data, 11 reserved; all 8 bits.
// - Set and index together form one 16-bit internal address.
// - Index advances after each complete location access to a table set through the data register.
// - Single-location sets ignore the index register.
// - For table sets, set bit 0 is the read-versus-write command.
// - 24-bit locations move as three bytes: red, green, blue.
// - Writing set or index returns the component counter to red.
// - Unused bits of narrow registers read back as zero.
// - Sets 2 and 3 write and read the 256-entry pseudo-colour table.
// - Sets 32 and 33 write and read the four-entry overlay table.
// - Sets 64, 67, 70, 73, 74, 75 are read/write control registers.
// - Sets 128 and 129 read checksum low and middle bytes; reserved sets inert.
// - Low vertical sync clears all three checksum accumulators.
// - Set 130 reads checksum upper byte; sets 131 to 255 are reserved.
// - Index increments after each three-byte table group.
package ihp_pkg;

  // ****************************************
  // Port select codes
  // ****************************************
  localparam logic [1:0] SEL_SET = 2'h0;
  localparam logic [1:0] SEL_INDEX = 2'h1;
  localparam logic [1:0] SEL_DATA = 2'h2;
  localparam logic [1:0] SEL_RSV = 2'h3;

  // ****************************************
  // Register set codes
  // ****************************************
  localparam logic [7:0] SET_TRUE_WR = 8'h00;
  localparam logic [7:0] SET_TRUE_RD = 8'h01;
  localparam logic [7:0] SET_PSEUDO_WR = 8'h02;
  localparam logic [7:0] SET_PSEUDO_RD = 8'h03;
  localparam logic [7:0] SET_OVL_WR = 8'h20;
  localparam logic [7:0] SET_OVL_RD = 8'h21;
  localparam logic [7:0] SET_PSEUDO_MASK = 8'h40;
  localparam logic [7:0] SET_OVL_MASK = 8'h43;
  localparam logic [7:0] SET_CONVERTER = 8'h46;
  localparam logic [7:0] SET_PIXEL_FMT = 8'h49;
  localparam logic [7:0] SET_PAN = 8'h4a;
  localparam logic [7:0] SET_FIELD_SEL = 8'h4b;
  localparam logic [7:0] SET_SIG_LOW = 8'h80;
  localparam logic [7:0] SET_SIG_MID = 8'h81;
  localparam logic [7:0] SET_SIG_HIGH = 8'h82;

  // ****************************************
  // Field masks, depths and reset values
  // ****************************************
  localparam logic [7:0] MASK_OVL = 8'h03;
  localparam logic [7:0] MASK_CONV = 8'h1f;
  localparam logic [7:0] MASK_PIX = 8'h7f;
  localparam logic [7:0] MASK_PAN = 8'h0f;
  localparam logic [7:0] MASK_FIELD = 8'h03;
  localparam logic [7:0] OVL_LAST = 8'h03;
  localparam int LUT_DEPTH = 256;
  localparam int OVL_DEPTH = 4;
  localparam int CHANNELS = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_SUM = 24'h000000;

  typedef enum logic [1:0] {
    COMP_RED = 2'b00,
    COMP_GREEN = 2'b01,
    COMP_BLUE = 2'b10
  } ihp_comp_e;

  typedef struct packed {
    logic [7:0] pseudoMask;
    logic [1:0] overlayEnable;
    logic [4:0] converterCtrl;
    logic [6:0] pixelFormat;
    logic [3:0] panDelay;
    logic [1:0] fieldSelect;
  } ihp_ctrl_s;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } ihp_pixel_s;

endpackage : ihp_pkg

// ==== logic/ihp_signature.sv ====
// Per-channel frame checksum accumulators.
// Assumes blank and vertical sync are synchronous to core_clk.
`timescale 1ns/100ps
module ihp_signature
  import ihp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input ihp_pixel_s dacPixel,
  input wire logic blankN,
  input wire logic vsyncN,
  output logic [2:0][23:0] sums
);

  logic [2:0][7:0] chanBytes;

  assign chanBytes = {dacPixel.blue, dacPixel.green, dacPixel.red};

  // ****************************************
  // Accumulators
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_ff @(posedge core_clk) begin
        if (rst || !vsyncN) begin
          sums[ch] <= RST_SUM;
        end else if (blankN) begin
          sums[ch] <= sums[ch] + {16'h0000, chanBytes[ch]};
        end
      end

      property p_clear;
        @(posedge core_clk) disable iff (rst)
        !vsyncN |=> (sums[ch] == RST_SUM);
      endproperty
      a_clear: assert property (p_clear) else $error("checksum not cleared by sync");
    end
  endgenerate

endmodule : ihp_signature

// ==== logic/ihp_host_port.sv ====
// Host programming port: strobes, pointer registers, colour tables, controls.
// Assumes host strobes, select lines and data are synchronous to core_clk.
`timescale 1ns/100ps
module ihp_host_port
  import ihp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic [1:0] portSelect,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  input ihp_pixel_s dacPixel,
  input wire logic blankN,
  input wire logic vsyncN,
  output ihp_ctrl_s ctrl
);

  // ****************************************
  // Declarations
  // ****************************************
  logic wrPrev_reg;
  logic rdPrev_reg;
  logic [1:0] selWr_reg;
  logic [1:0] selRd_reg;
  logic [7:0] tableSet_reg;
  logic [7:0] location_reg;
  ihp_comp_e comp_reg;
  ihp_ctrl_s ctrl_reg;
  logic [7:0] hostDataOut_reg;
  logic hostDataOe_reg;
  logic [7:0] trueMem [0:CHANNELS-1][0:LUT_DEPTH-1];
  logic [7:0] pseudoMem [0:CHANNELS-1][0:LUT_DEPTH-1];
  logic [7:0] overlayMem [0:CHANNELS-1][0:OVL_DEPTH-1];
  logic [2:0][23:0] sums;
  logic wrFall;
  logic wrRise;
  logic rdFall;
  logic rdRise;
  logic dataWrite;
  logic dataDone;
  logic tableSet;
  logic groupSet;
  logic ovlInRange;
  logic [1:0] compIdx;
  logic [15:0] internalAddr;
  logic [7:0] readByte;

  assign wrFall = wrPrev_reg && !wrN;
  assign wrRise = !wrPrev_reg && wrN;
  assign rdFall = rdPrev_reg && !rdN;
  assign rdRise = !rdPrev_reg && rdN;
  assign compIdx = comp_reg;
  assign internalAddr = {tableSet_reg, location_reg};
  assign ovlInRange = internalAddr[7:0] <= OVL_LAST;
  assign dataWrite = wrRise && (selWr_reg == SEL_DATA);
  assign dataDone = dataWrite || (rdRise && (selRd_reg == SEL_DATA));
  assign hostDataOut = hostDataOut_reg;
  assign hostDataOe = hostDataOe_reg;
  assign ctrl = ctrl_reg;

  always_comb begin
    tableSet = 1'b0;
    case (tableSet_reg)
      SET_TRUE_WR, SET_TRUE_RD, SET_PSEUDO_WR, SET_PSEUDO_RD, SET_OVL_WR, SET_OVL_RD: begin
        tableSet = 1'b1;
      end
      default: begin
        tableSet = 1'b0;
      end
    endcase
    groupSet = tableSet || (tableSet_reg == SET_SIG_LOW) || (tableSet_reg == SET_SIG_MID)
      || (tableSet_reg == SET_SIG_HIGH);
  end

  // ****************************************
  // Strobe edge tracking
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPrev_reg <= 1'b1;
      rdPrev_reg <= 1'b1;
    end else begin
      wrPrev_reg <= wrN;
      rdPrev_reg <= rdN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      selWr_reg <= SEL_RSV;
    end else if (wrFall) begin
      selWr_reg <= portSelect;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      selRd_reg <= SEL_RSV;
    end else if (rdFall) begin
      selRd_reg <= portSelect;
    end
  end

  // ****************************************
  // Pointer registers
  // ****************************************
  // set register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tableSet_reg <= RST_BYTE;
    end else if (wrRise && (selWr_reg == SEL_SET)) begin
      tableSet_reg <= hostDataIn;
    end
  end

  // Index is loaded by the host or advanced after a full three-byte group.
  // index auto-increment
  always_ff @(posedge core_clk) begin
    if (rst) begin
      location_reg <= RST_BYTE;
    end else if (wrRise && (selWr_reg == SEL_INDEX)) begin
      location_reg <= hostDataIn;
    end else if (dataDone && tableSet && (comp_reg == COMP_BLUE)) begin
      location_reg <= location_reg + 8'h01;
    end
  end

  // ****************************************
  // Component sequencer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      comp_reg <= COMP_RED;
    end else if (wrRise && ((selWr_reg == SEL_SET) || (selWr_reg == SEL_INDEX))) begin
      comp_reg <= COMP_RED;
    end else if (dataDone && groupSet) begin
      case (comp_reg)
        COMP_RED: begin
          comp_reg <= COMP_GREEN;
        end
        COMP_GREEN: begin
          comp_reg <= COMP_BLUE;
        end
        default: begin
          comp_reg <= COMP_RED;
        end
      endcase
    end
  end

  // ****************************************
  // Colour tables
  // ****************************************
  // bit 0 clear means write; a write to a read set is dropped.
  always_ff @(posedge core_clk) begin
    if (dataWrite && (compIdx < 2'd3)) begin
      case (tableSet_reg)
        SET_TRUE_WR: begin
          trueMem[compIdx][location_reg] <= hostDataIn;
        end
        SET_PSEUDO_WR: begin
          pseudoMem[compIdx][location_reg] <= hostDataIn;
        end
        SET_OVL_WR: begin
          if (ovlInRange) begin
            overlayMem[compIdx][location_reg[1:0]] <= hostDataIn;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // single-location controls; index not used here
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= '0;
    end else if (dataWrite) begin
      case (tableSet_reg)
        SET_PSEUDO_MASK: begin
          ctrl_reg.pseudoMask <= hostDataIn;
        end
        SET_OVL_MASK: begin
          ctrl_reg.overlayEnable <= hostDataIn[1:0];
        end
        SET_CONVERTER: begin
          ctrl_reg.converterCtrl <= hostDataIn[4:0];
        end
        SET_PIXEL_FMT: begin
          ctrl_reg.pixelFormat <= hostDataIn[6:0];
        end
        SET_PAN: begin
          ctrl_reg.panDelay <= hostDataIn[3:0];
        end
        SET_FIELD_SEL: begin
          ctrl_reg.fieldSelect <= hostDataIn[1:0];
        end
        // reserved and read-only sets ignore writes
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Read data selection
  // ****************************************
  always_comb begin
    readByte = RST_BYTE;
    case (portSelect)
      SEL_SET: begin
        readByte = tableSet_reg;
      end
      SEL_INDEX: begin
        readByte = location_reg;
      end
      SEL_DATA: begin
        case (tableSet_reg)
          SET_TRUE_RD: begin
            readByte = (compIdx < 2'd3) ? trueMem[compIdx][location_reg] : RST_BYTE;
          end
          SET_PSEUDO_RD: begin
            readByte = (compIdx < 2'd3) ? pseudoMem[compIdx][location_reg] : RST_BYTE;
          end
          SET_OVL_RD: begin
            if (ovlInRange && (compIdx < 2'd3)) begin
              readByte = overlayMem[compIdx][location_reg[1:0]];
            end
          end
          SET_PSEUDO_MASK: begin
            readByte = ctrl_reg.pseudoMask;
          end
          SET_OVL_MASK: begin
            readByte = {6'h00, ctrl_reg.overlayEnable} & MASK_OVL;
          end
          SET_CONVERTER: begin
            readByte = {3'h0, ctrl_reg.converterCtrl} & MASK_CONV;
          end
          SET_PIXEL_FMT: begin
            readByte = {1'h0, ctrl_reg.pixelFormat} & MASK_PIX;
          end
          SET_PAN: begin
            readByte = {4'h0, ctrl_reg.panDelay} & MASK_PAN;
          end
          SET_FIELD_SEL: begin
            readByte = {6'h00, ctrl_reg.fieldSelect} & MASK_FIELD;
          end
          SET_SIG_LOW: begin
            readByte = (compIdx < 2'd3) ? sums[compIdx][7:0] : RST_BYTE;
          end
          SET_SIG_MID: begin
            readByte = (compIdx < 2'd3) ? sums[compIdx][15:8] : RST_BYTE;
          end
          SET_SIG_HIGH: begin
            readByte = (compIdx < 2'd3) ? sums[compIdx][23:16] : RST_BYTE;
          end
          default: begin
            readByte = RST_BYTE;
          end
        endcase
      end
      default: begin
        readByte = RST_BYTE;
      end
    endcase
  end

  // ****************************************
  // Host data bus drive
  // ****************************************
  // The byte is frozen at the strobe fall so it stays stable while the host samples it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hostDataOut_reg <= RST_BYTE;
    end else if (rdFall) begin
      hostDataOut_reg <= readByte;
    end
  end

  // drive until strobe rises; reserved stays off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hostDataOe_reg <= 1'b0;
    end else if (rdFall) begin
      hostDataOe_reg <= (portSelect != SEL_RSV);
    end else if (rdRise) begin
      hostDataOe_reg <= 1'b0;
    end
  end

  ihp_signature u_signature (
    .core_clk(core_clk),
    .rst(rst),
    .dacPixel(dacPixel),
    .blankN(blankN),
    .vsyncN(vsyncN),
    .sums(sums)
  );

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_setWrite;
    wrRise && (selWr_reg == SEL_SET);
  endsequence

  sequence s_indexWrite;
    wrRise && (selWr_reg == SEL_INDEX);
  endsequence

  property p_selCapture;
    @(posedge core_clk) disable iff (rst)
    wrFall |=> (selWr_reg == $past(portSelect));
  endproperty
  a_selCapture: assert property (p_selCapture) else $error("select not captured");

  property p_setLatch;
    @(posedge core_clk) disable iff (rst)
    s_setWrite |=> (tableSet_reg == $past(hostDataIn));
  endproperty
  a_setLatch: assert property (p_setLatch) else $error("set byte not latched");

  property p_readHold;
    @(posedge core_clk) disable iff (rst)
    (rdFall && (portSelect != SEL_RSV)) ##1 (!rdRise [*2]) |-> hostDataOe && $stable(hostDataOut);
  endproperty
  a_readHold: assert property (p_readHold) else $error("read data not held");

  property p_readRelease;
    @(posedge core_clk) disable iff (rst)
    rdRise |=> !hostDataOe;
  endproperty
  a_readRelease: assert property (p_readRelease) else $error("bus not released");

  property p_reservedQuiet;
    @(posedge core_clk) disable iff (rst)
    (rdFall && (portSelect == SEL_RSV)) |=> !hostDataOe;
  endproperty
  a_reservedQuiet: assert property (p_reservedQuiet) else $error("reserved read drove bus");

  property p_compRestart;
    @(posedge core_clk) disable iff (rst)
    (s_setWrite or s_indexWrite) |=> (comp_reg == COMP_RED);
  endproperty
  a_compRestart: assert property (p_compRestart) else $error("component not reset");

  property p_groupAdvance;
    @(posedge core_clk) disable iff (rst)
    (dataDone && tableSet && (comp_reg == COMP_BLUE))
      |=> (location_reg == $past(location_reg) + 8'h01) && (comp_reg == COMP_RED);
  endproperty
  a_groupAdvance: assert property (p_groupAdvance) else $error("index not advanced");

  property p_midGroupHold;
    @(posedge core_clk) disable iff (rst)
    (dataDone && tableSet && (comp_reg == COMP_RED)) |=> $stable(location_reg)
      && (comp_reg == COMP_GREEN);
  endproperty
  a_midGroupHold: assert property (p_midGroupHold) else $error("index moved mid group");

  property p_singleNoAdvance;
    @(posedge core_clk) disable iff (rst)
    (dataDone && !groupSet) |=> $stable(location_reg) && $stable(comp_reg);
  endproperty
  a_singleNoAdvance: assert property (p_singleNoAdvance) else $error("single set moved");

  property p_zeroUnused;
    @(posedge core_clk) disable iff (rst)
    (rdFall && (portSelect == SEL_DATA) && (tableSet_reg == SET_OVL_MASK))
      |=> (hostDataOut[7:2] == 6'h00);
  endproperty
  a_zeroUnused: assert property (p_zeroUnused) else $error("unused bits nonzero");

endmodule : ihp_host_port

// ==== verification/ihp_host_model.sv ====
// Host processor model driving the strobe bus of the host port.
// Assumes the design samples strobes on the rising edge of core_clk.
`timescale 1ns/100ps
module ihp_host_model (
  input wire logic core_clk,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe,
  output logic wrN,
  output logic rdN,
  output logic [1:0] portSelect,
  output logic [7:0] hostDataIn
);
  // ****************************************
  // Bus cycles
  // ****************************************
  initial begin
    wrN = 1'b1;
    rdN = 1'b1;
    portSelect = 2'h0;
    hostDataIn = 8'h00;
  end

  // select held across the fall, one access at a time.
  task automatic busWrite(input logic [1:0] sel, input logic [7:0] data);
    @(negedge core_clk);
    wrN = 1'b0;
    portSelect = sel;
    @(negedge core_clk);
    wrN = 1'b1;
    hostDataIn = data;
    @(negedge core_clk);
    // A released bus must not look like the last byte.
    hostDataIn = ~data;
    portSelect = ~sel;
  endtask : busWrite

  // read select held until the answer is taken.
  task automatic busRead(input logic [1:0] sel, output logic [7:0] data, output logic driven);
    int n;
    @(negedge core_clk);
    rdN = 1'b0;
    portSelect = sel;
    driven = 1'b0;
    n = 0;
    while (!driven && n < 4) begin
      @(posedge core_clk);
      #1;
      driven = (hostDataOe === 1'b1);
      n++;
    end
    data = hostDataOut;
    // Keep the strobe low a while longer: the byte must stand until the strobe rises.
    repeat (2) @(posedge core_clk);
    #1;
    driven = driven && (hostDataOe === 1'b1) && (hostDataOut === data);
    @(negedge core_clk);
    rdN = 1'b1;
    portSelect = ~sel;
    @(negedge core_clk);
  endtask : busRead
endmodule : ihp_host_model

// ==== verification/ihp_host_port_tb.sv ====
// Self-checking bench for the host port, with a behavioural register model.
// Assumes the host model instance drives all strobe bus inputs.
`timescale 1ns/100ps
module ihp_host_port_tb;
  import ihp_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wrN;
  logic rdN;
  logic [1:0] portSelect;
  logic [7:0] hostDataIn;
  logic [7:0] hostDataOut;
  logic hostDataOe;
  ihp_pixel_s dacPixel = '0;
  logic blankN = 1'b0;
  logic vsyncN = 1'b1;
  ihp_ctrl_s ctrl;
  int nMismatch = 0;
  int numChecks = 0;
  logic [7:0] regM [256];
  logic [7:0] trueT [3][256];
  logic [7:0] pseudoT [3][256];
  logic [7:0] ovlT [3][4];
  logic [23:0] sums [3];
  int setM = 0;
  int idxM = 0;
  int compM = 0;

  always #5 core_clk = ~core_clk;

  ihp_host_model host (.core_clk(core_clk), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .wrN(wrN), .rdN(rdN), .portSelect(portSelect), .hostDataIn(hostDataIn));

  ihp_host_port dut (.core_clk(core_clk), .rst(rst), .wrN(wrN), .rdN(rdN),
    .portSelect(portSelect), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .dacPixel(dacPixel), .blankN(blankN), .vsyncN(vsyncN),
    .ctrl(ctrl));

  // ****************************************
  // Model and checking helpers
  // ****************************************
  task automatic check(input logic [27:0] seen, input logic [27:0] exp, input string what);
    numChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic reportAndStop;
    if (nMismatch == 0 && numChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : reportAndStop

  function automatic logic [7:0] maskOf(input int s);
    case (s)
      64: return 8'hff;
      67: return MASK_OVL;
      70: return MASK_CONV;
      73: return MASK_PIX;
      74: return MASK_PAN;
      75: return MASK_FIELD;
      default: return 8'h00;
    endcase
  endfunction : maskOf

  // Checksum sets walk the colours but leave the index alone.
  function automatic void step(input bit adv);
    compM++;
    if (compM == 3) begin
      compM = 0;
      if (adv) idxM = (idxM + 1) % 256;
    end
  endfunction : step

  // Table and checksum sets walk the colours on every data access, reads and writes alike.
  function automatic void advance;
    if (setM <= 3 || setM == 32 || setM == 33) step(1'b1);
    else if (setM >= 128 && setM <= 130) step(1'b0);
  endfunction : advance

  task automatic wr(input logic [1:0] sel, input logic [7:0] v);
    host.busWrite(sel, v);
    if (sel == SEL_SET) begin
      setM = v;
      compM = 0;
    end else if (sel == SEL_INDEX) begin
      idxM = v;
      compM = 0;
    end else if (sel == SEL_DATA) begin
      if (maskOf(setM) != 8'h00) regM[setM] = v & maskOf(setM);
      else if (setM == 0) trueT[compM][idxM] = v;
      else if (setM == 2) pseudoT[compM][idxM] = v;
      else if (setM == 32 && idxM < OVL_DEPTH) ovlT[compM][idxM] = v;
      advance();
    end
  endtask : wr

  task automatic rdCheck;
    logic [7:0] d;
    logic [7:0] e;
    logic drv;
    e = 8'h00;
    if (maskOf(setM) != 8'h00) e = regM[setM];
    else if (setM == 1) e = trueT[compM][idxM];
    else if (setM == 3) e = pseudoT[compM][idxM];
    else if (setM == 33 && idxM < OVL_DEPTH) e = ovlT[compM][idxM];
    else if (setM >= 128 && setM <= 130) e = sums[compM][8*(setM-128) +: 8];
    host.busRead(SEL_DATA, d, drv);
    check(drv, 1'b1, "read not driven");
    check(d, e, "read data");
    advance();
  endtask : rdCheck

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    int singles [6];
    int n;
    logic [7:0] s;
    logic [7:0] base;
    logic [7:0] d;
    logic drv;
    singles = '{64, 67, 70, 73, 74, 75};
    void'($urandom(24));
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check(hostDataOe, 1'b0, "oe after reset");
    check(ctrl, 28'h0, "ctrl after reset");
    // full random bytes, index ignored, readback twice
    for (int i = 0; i < 6; i++) begin
      wr(SEL_SET, 8'(singles[i]));
      host.busRead(SEL_SET, d, drv);
      check(d, 8'(singles[i]), "set readback");
      wr(SEL_INDEX, 8'($urandom));
      wr(SEL_DATA, 8'($urandom));
      rdCheck();
      rdCheck();
      // host keeps unused bits at zero
      wr(SEL_DATA, 8'($urandom) & maskOf(singles[i]));
      rdCheck();
    end
    repeat (2) @(negedge core_clk);
    check(ctrl, {regM[64], regM[67][1:0], regM[70][4:0], regM[73][6:0], regM[74][3:0],
      regM[75][1:0]}, "ctrl fields");
    // wrap, restart and reserved select mid-burst
    for (int t = 0; t < 3; t++) begin
      s = (t == 0) ? SET_TRUE_WR : (t == 1) ? SET_PSEUDO_WR : SET_OVL_WR;
      base = (t == 2) ? 8'h02 : 8'hfe;
      wr(SEL_SET, s);
      wr(SEL_INDEX, base);
      wr(SEL_DATA, 8'($urandom));
      wr(SEL_INDEX, base);
      wr(SEL_RSV, 8'($urandom));
      repeat (9) wr(SEL_DATA, 8'($urandom));
      wr(SEL_SET, s | 8'h01);
      wr(SEL_INDEX, base);
      repeat (9) rdCheck();
      host.busRead(SEL_INDEX, d, drv);
      check(d, 8'(idxM), "index readback");
      // data written into a read set is dropped
      wr(SEL_DATA, 8'($urandom));
      wr(SEL_INDEX, base);
      repeat (3) rdCheck();
    end
    wr(SEL_SET, SET_TRUE_RD);
    wr(SEL_INDEX, 8'hfe);
    repeat (3) rdCheck();
    // reserved set is inert and reads zero
    wr(SEL_SET, 8'h05);
    wr(SEL_DATA, 8'($urandom));
    rdCheck();
    host.busRead(SEL_RSV, d, drv);
    check(drv, 1'b0, "reserved select drove bus");
    // clear, then accumulate a known number of pixels
    n = 3 + $urandom % 6;
    dacPixel = 24'($urandom);
    vsyncN = 1'b0;
    @(negedge core_clk);
    vsyncN = 1'b1;
    blankN = 1'b1;
    repeat (n) @(negedge core_clk);
    blankN = 1'b0;
    sums[0] = 24'(n * dacPixel.red);
    sums[1] = 24'(n * dacPixel.green);
    sums[2] = 24'(n * dacPixel.blue);
    dacPixel = 24'($urandom);
    // all three bytes of every channel
    for (int k = 0; k < 3; k++) begin
      wr(SEL_SET, SET_SIG_LOW + 8'(k));
      repeat (3) rdCheck();
    end
    vsyncN = 1'b0;
    @(negedge core_clk);
    vsyncN = 1'b1;
    sums[0] = RST_SUM;
    sums[1] = RST_SUM;
    sums[2] = RST_SUM;
    // cleared middle bytes read back as zero
    wr(SEL_SET, SET_SIG_MID);
    repeat (3) rdCheck();
    reportAndStop();
  end

  // Cuts a hung run short.
  initial begin
    #900000;
    nMismatch++;
    reportAndStop();
  end
endmodule : ihp_host_port_tb
